// *** hdl/clock_control_reg_reset.v ***
// keep-alive system clock control register with key, reset loading
`timescale 1ns/1ns
`include "clock_control_consts.vh"
module clock_control_reg_reset #(
    parameter       OLD_ENG_DEFAULT = 0,
    parameter [7:0] LIMP_DECODE     = 8'h0E
) (
    input  wire        core_clk,
    input  wire        rst_n,
    input  wire        hardResetPin,
    input  wire [2:0]  modeClkSelPins,
    input  wire [31:0] resetConfigWord,
    input  wire        backupClockActive,
    input  wire [31:0] busAddr,
    input  wire [31:0] busWrData,
    input  wire        busWrite,
    input  wire        busRead,
    output reg  [31:0] busRdData,
    output reg  [31:0] systemClockControl,
    output reg         keyOpen,
    output reg         porLoadDone
);

    // ------------------------------------------------------------------
    // power-on constant, chosen by silicon revision
    // ------------------------------------------------------------------
    localparam [31:0] POR_CONST = (OLD_ENG_DEFAULT != 0) ?
                                  `SCC_POR_VALUE_OLD : `SCC_POR_VALUE;

    // power-on settle sequencer states
    localparam [1:0] ST_SETTLE = 2'b00;
    localparam [1:0] ST_LOAD   = 2'b01;
    localparam [1:0] ST_RUN    = 2'b10;

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    wire [36:0] syncIn;
    wire [36:0] syncOut;
    wire [2:0]  modeSync;
    wire [31:0] cfgSync;
    wire        hardReset;
    wire        backupSync;
    wire        hitReg;
    wire        hitKey;
    wire        regWrite;
    wire        keyWrite;
    wire        keyRead;
    wire        limpDecoded;
    wire [31:0] readWord;

    reg  [1:0]  porState;
    reg  [1:0]  next_porState;
    reg  [2:0]  settleCount;
    reg  [31:0] next_control;
    reg  [31:0] writeValue;
    reg  [31:0] porValue;
    reg         next_keyOpen;

    // ------------------------------------------------------------------
    // synchronize all pins before any logic looks at them
    // ------------------------------------------------------------------
    assign syncIn = {hardResetPin, backupClockActive, modeClkSelPins, resetConfigWord};

    pin_synchronizer #(
        .WIDTH (37)
    ) uSync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .asyncIn  (syncIn),
        .syncOut  (syncOut)
    );

    // split synchronized bundle
    assign hardReset = syncOut[36];
    assign backupSync = syncOut[35];
    assign modeSync  = syncOut[34:32];
    assign cfgSync   = syncOut[31:0];

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    assign hitReg   = (busAddr == `SCC_ADDR);
    assign hitKey   = (busAddr == `SCC_KEY_ADDR);
    assign regWrite = busWrite & hitReg & keyOpen & !hardReset &
                      (porState == ST_RUN);
    assign keyWrite = busWrite & hitKey;
    assign keyRead  = busRead & hitKey;

    // limp mode decode, one table bit per pin combination
    assign limpDecoded = LIMP_DECODE[modeSync];

    // ------------------------------------------------------------------
    // power-on settle: wait for the synchronizers to fill, then load
    // ------------------------------------------------------------------
    always @* begin
        next_porState = porState;
        case (porState)
            ST_SETTLE: begin
                if (settleCount == `SCC_POR_SETTLE) begin
                    next_porState = ST_LOAD;
                end
            end
            ST_LOAD: begin
                next_porState = ST_RUN;
            end
            ST_RUN: begin
                next_porState = ST_RUN;
            end
            default: begin
                next_porState = ST_SETTLE;
            end
        endcase
    end

    // settle counter and state register
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            porState    <= ST_SETTLE;
            settleCount <= 3'h0;
            porLoadDone <= 1'b0;
        end else begin
            porState <= next_porState;
            if (porState == ST_SETTLE) begin
                settleCount <= settleCount + 3'h1;
            end
            if (porState == ST_LOAD) begin
                porLoadDone <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // power-on load value: constants plus pin-derived fields
    // ------------------------------------------------------------------
    always @* begin
        porValue = POR_CONST;
        porValue[`SCC_RTC_DIV]  = |modeSync;
        porValue[`SCC_RTC_SRC]  = modeSync[2];
        porValue[`SCC_LIMP_EN]  = limpDecoded;
        porValue[`SCC_CLKOUT_LO] = cfgSync[`SCC_CLKOUT_LO];
        porValue[`SCC_BUSDIV_HI:`SCC_BUSDIV_LO] = cfgSync[`SCC_BUSDIV_HI:`SCC_BUSDIV_LO];
    end

    // ------------------------------------------------------------------
    // software write value with write-once and conditional bits
    // ------------------------------------------------------------------
    always @* begin
        writeValue = (busWrData & `SCC_WRITE_MASK) |
                     (systemClockControl & ~`SCC_WRITE_MASK);
        // lock bits stay set once written, until power-on or hard reset
        if (systemClockControl[`SCC_MULT_LOCK]) begin
            writeValue[`SCC_MULT_LOCK] = 1'b1;
        end
        if (systemClockControl[`SCC_LOWPWR_LOCK]) begin
            writeValue[`SCC_LOWPWR_LOCK] = 1'b1;
        end
        // switch to backup clock is ignored without limp mode
        if (!systemClockControl[`SCC_LIMP_EN]) begin
            writeValue[`SCC_TO_BACKUP] = 1'b0;
        end
        writeValue[`SCC_BACKUP_STAT] = 1'b0;
    end

    // ------------------------------------------------------------------
    // next register value: power-on load, hard reset, software write
    // ------------------------------------------------------------------
    always @* begin
        next_control = systemClockControl;
        if (porState == ST_LOAD) begin
            next_control = porValue;
        end else if (hardReset) begin
            // only the affected fields change; the rest persist
            next_control = (systemClockControl & ~`SCC_HARD_MASK) |
                           `SCC_HARD_VALUE;
            next_control = (next_control & ~`SCC_CFG_MASK) |
                           (cfgSync & `SCC_CFG_MASK);
        end else if (regWrite) begin
            next_control = writeValue;
        end
    end

    // the single keep-alive control register
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            systemClockControl <= POR_CONST;
        end else begin
            systemClockControl <= next_control;
        end
    end

    // ------------------------------------------------------------------
    // key: exact value opens, anything else locks
    // ------------------------------------------------------------------
    always @* begin
        next_keyOpen = keyOpen;
        if (keyWrite) begin
            next_keyOpen = (busWrData == `SCC_KEY_OPEN);
        end else if (keyRead) begin
            next_keyOpen = 1'b0; // reading the key counts as a lock
        end
    end

    // key state, open after power-on, untouched by hard reset
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            keyOpen <= 1'b1;
        end else begin
            keyOpen <= next_keyOpen;
        end
    end

    // ------------------------------------------------------------------
    // read data, one cycle after the read strobe
    // ------------------------------------------------------------------
    assign readWord = {systemClockControl[31:20], backupSync, systemClockControl[18:0]};

    // registered read port; key and unmapped addresses read zero
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busRdData <= 32'h00000000;
        end else if (busRead && hitReg) begin
            busRdData <= readWord;
        end else begin
            busRdData <= 32'h00000000;
        end
    end

endmodule

// *** hdl/clock_control_consts.vh ***
// constants for the keep-alive system clock control register
`ifndef CLOCK_CONTROL_CONSTS_VH
`define CLOCK_CONTROL_CONSTS_VH

// ----------------------------------------------------------------------
// addresses and key value
// ----------------------------------------------------------------------
`define SCC_ADDR            32'h002FC280
`define SCC_KEY_ADDR        32'h002FC380
`define SCC_KEY_OPEN        32'h55CCAA33

// ----------------------------------------------------------------------
// field positions (bit 31 is the msb of the register)
// ----------------------------------------------------------------------
`define SCC_BACKUP_DIS      31
`define SCC_CLKOUT_HI       30
`define SCC_CLKOUT_LO       29
`define SCC_SWITCH_DIS      28
`define SCC_MULT_LOCK       27
`define SCC_LOWPWR_LOCK     26
`define SCC_TIMEBASE_SRC    25
`define SCC_RTC_DIV         24
`define SCC_TO_BACKUP       23
`define SCC_PERIPH_REQ      21
`define SCC_RTC_SRC         20
`define SCC_BACKUP_STAT     19
`define SCC_BUSDIV_HI       18
`define SCC_BUSDIV_LO       17
`define SCC_LIMP_EN         16
`define SCC_ENG_HI          13
`define SCC_ENG_LO          8

// ----------------------------------------------------------------------
// reset values and masks
// ----------------------------------------------------------------------
`define SCC_POR_VALUE       32'h80203F00
`define SCC_POR_VALUE_OLD   32'h80200100
`define SCC_WRITE_MASK      32'hFFB7FF77
`define SCC_HARD_MASK       32'h6C6600FF
`define SCC_HARD_VALUE      32'h00200000
`define SCC_CFG_MASK        32'h20060000
`define SCC_ENG_ONES        6'h3F
`define SCC_ENG_OLD         6'h01

// ----------------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------------
`define SCC_SYNC_STAGES     2
`define SCC_POR_SETTLE      3'h3

`endif

// *** hdl/pin_synchronizer.v ***
// two-stage synchronizer for a group of asynchronous inputs
`timescale 1ns/1ns
module pin_synchronizer #(
    parameter WIDTH = 1
) (
    input  wire             core_clk,
    input  wire             rst_n,
    input  wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);

    // ------------------------------------------------------------------
    // one pair of flops per bit
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : gSync
            reg stageA;
            reg stageB;
            // first flop feeds only the second
            always @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    stageA <= 1'b0;
                    stageB <= 1'b0;
                end else begin
                    stageA <= asyncIn[i];
                    stageB <= stageA;
                end
            end
            assign syncOut[i] = stageB;
        end
    endgenerate

endmodule

// *** verification/clock_control_chk.sv ***
// port assertions for the clock control register
`timescale 1ns/1ns
`include "clock_control_consts.vh"
module clock_control_chk #(
    parameter [7:0] LIMP_DECODE = 8'h0E
) (
    input wire        core_clk,
    input wire        rst_n,
    input wire        hardResetPin,
    input wire [2:0]  modeClkSelPins,
    input wire [31:0] resetConfigWord,
    input wire        backupClockActive,
    input wire [31:0] busAddr,
    input wire [31:0] busWrData,
    input wire        busWrite,
    input wire        busRead,
    input wire [31:0] busRdData,
    input wire [31:0] systemClockControl,
    input wire        keyOpen,
    input wire        porLoadDone
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    key_open_a: assert property (
        busWrite && busAddr == `SCC_KEY_ADDR && busWrData == `SCC_KEY_OPEN |=> keyOpen)
        else $error("key did not open");
    key_lock_a: assert property (
        busWrite && busAddr == `SCC_KEY_ADDR && busWrData != `SCC_KEY_OPEN |=> !keyOpen)
        else $error("key did not lock");
    key_read_a: assert property (
        busRead && busAddr == `SCC_KEY_ADDR |=> !keyOpen && busRdData == 32'h0)
        else $error("key read did not lock or returned data");
    locked_write_a: assert property (
        (!hardResetPin)[*4] ##0 (busWrite && busAddr == `SCC_ADDR && !keyOpen && porLoadDone)
        |=> $stable(systemClockControl))
        else $error("write changed a locked register");
    write_effect_a: assert property (
        (!hardResetPin)[*4] ##0 (busWrite && busAddr == `SCC_ADDR && keyOpen && porLoadDone)
        |=> ((systemClockControl ^ $past(busWrData)) & 32'hF337FF77) == 32'h0)
        else $error("register write not stored");
    read_back_a: assert property (
        busRead && busAddr == `SCC_ADDR
        |=> (busRdData & 32'hFFF7FFFF) == ($past(systemClockControl) & 32'hFFF7FFFF))
        else $error("read data differs from register");
    hard_fields_a: assert property (
        (hardResetPin && $stable(resetConfigWord))[*4]
        |-> (systemClockControl & `SCC_HARD_MASK)
            == (`SCC_HARD_VALUE | (resetConfigWord & `SCC_CFG_MASK)))
        else $error("hard reset fields wrong");
    hard_keep_a: assert property (
        hardResetPin[*4] |=> $stable(systemClockControl & 32'h9391FF00))
        else $error("unaffected field changed in hard reset");
    rtc_load_a: assert property (
        $rose(porLoadDone) |-> systemClockControl[24] == (|modeClkSelPins)
            && systemClockControl[20] == modeClkSelPins[2])
        else $error("rtc fields not loaded from pins");
    limp_load_a: assert property (
        $rose(porLoadDone) |-> systemClockControl[16] == LIMP_DECODE[modeClkSelPins])
        else $error("limp enable not decoded from pins");
endmodule

bind clock_control_reg_reset clock_control_chk #(.LIMP_DECODE(LIMP_DECODE)) chk (
    .core_clk(core_clk), .rst_n(rst_n), .hardResetPin(hardResetPin),
    .modeClkSelPins(modeClkSelPins), .resetConfigWord(resetConfigWord),
    .backupClockActive(backupClockActive), .busAddr(busAddr), .busWrData(busWrData),
    .busWrite(busWrite), .busRead(busRead), .busRdData(busRdData),
    .systemClockControl(systemClockControl), .keyOpen(keyOpen), .porLoadDone(porLoadDone));

// *** verification/mode_pin_source.sv ***
// model of the reset supervisor and the mode pin and config word source
`timescale 1ns/1ns
module mode_pin_source (
    input  wire        core_clk,
    input  wire        supplyOk,
    input  wire [2:0]  pinLevel,
    input  wire [31:0] cfgWord,
    output reg         rstN,
    output wire [2:0]  modeClkSelPins,
    output wire [31:0] resetConfigWord
);
    // reset falls with the supply, rises one edge after all supplies are valid
    always @(posedge core_clk or negedge supplyOk) begin
        if (!supplyOk)
            rstN <= 1'b0;
        else
            rstN <= 1'b1;
    end
    // pins and config word held steady by the board
    assign modeClkSelPins  = pinLevel;
    assign resetConfigWord = cfgWord;
endmodule

// *** verification/test_clock_control_reg_reset.sv ***
// self-checking testbench for the clock control register
`timescale 1ns/1ns
`include "clock_control_consts.vh"
module test_clock_control_reg_reset;
    localparam [7:0] LIMP = 8'h0E;
    reg         core_clk, supplyOk, hardResetPin, backupClockActive, busWrite, busRead;
    reg  [2:0]  pinLevel;
    reg  [31:0] cfgWord, busAddr, busWrData;
    wire        rst_n, keyOpen, porLoadDone;
    wire [2:0]  modeClkSelPins;
    wire [31:0] resetConfigWord, busRdData, systemClockControl, oldCtl;
    integer     fails, n_compared, i;

    mode_pin_source src (.core_clk(core_clk), .supplyOk(supplyOk), .pinLevel(pinLevel),
        .cfgWord(cfgWord), .rstN(rst_n), .modeClkSelPins(modeClkSelPins),
        .resetConfigWord(resetConfigWord));
    clock_control_reg_reset #(.OLD_ENG_DEFAULT(0), .LIMP_DECODE(LIMP)) dut (
        .core_clk(core_clk), .rst_n(rst_n), .hardResetPin(hardResetPin),
        .modeClkSelPins(modeClkSelPins), .resetConfigWord(resetConfigWord),
        .backupClockActive(backupClockActive), .busAddr(busAddr), .busWrData(busWrData),
        .busWrite(busWrite), .busRead(busRead), .busRdData(busRdData),
        .systemClockControl(systemClockControl), .keyOpen(keyOpen), .porLoadDone(porLoadDone));
    // older silicon variant, only its engineering divide default is looked at
    clock_control_reg_reset #(.OLD_ENG_DEFAULT(1), .LIMP_DECODE(LIMP)) dutOld (
        .core_clk(core_clk), .rst_n(rst_n), .hardResetPin(hardResetPin),
        .modeClkSelPins(modeClkSelPins), .resetConfigWord(resetConfigWord),
        .backupClockActive(backupClockActive), .busAddr(busAddr), .busWrData(busWrData),
        .busWrite(busWrite), .busRead(busRead), .busRdData(),
        .systemClockControl(oldCtl), .keyOpen(), .porLoadDone());

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task check(input [31:0] seen, input [31:0] want);
        begin
            n_compared = n_compared + 1;
            if (seen !== want) begin
                fails = fails + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
            end
        end
    endtask
    task wr(input [31:0] a, input [31:0] d);
        begin
            @(posedge core_clk);
            busWrite  <= 1'b1;
            busAddr   <= a;
            busWrData <= d;
            @(posedge core_clk);
            busWrite  <= 1'b0;
            #1;
        end
    endtask
    task rd(input [31:0] a, input [31:0] want);
        begin
            @(posedge core_clk);
            busRead <= 1'b1;
            busAddr <= a;
            @(posedge core_clk);
            busRead <= 1'b0;
            #1 check(busRdData, want);
        end
    endtask
    // power-on cycle with new pin levels, waits for the pin load
    task por(input [2:0] p);
        begin
            @(posedge core_clk);
            pinLevel <= p;
            supplyOk <= 1'b0;
            repeat (6) @(posedge core_clk);
            supplyOk <= 1'b1;
            repeat (20) if (porLoadDone !== 1'b1) @(posedge core_clk);
            #1 check({31'h0, porLoadDone}, 32'h1);
        end
    endtask
    function [31:0] porExp(input [2:0] p);
        porExp = `SCC_POR_VALUE | (cfgWord & `SCC_CFG_MASK)
            | {7'h0, |p, 3'h0, p[2], 3'h0, LIMP[p], 16'h0};
    endfunction
    task complete_run;
        begin
            $display("compared %0d, mismatches %0d", n_compared, fails);
            if (fails == 0 && n_compared > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask

    // watchdog against a hung handshake
    initial begin
        #50000;
        fails = fails + 1;
        complete_run;
    end

    initial begin
        fails = 0;
        n_compared = 0;
        {supplyOk, hardResetPin, backupClockActive, busWrite, busRead} = 5'h00;
        busAddr = 32'h0;
        busWrData = 32'h0;
        pinLevel = 3'h0;
        cfgWord = 32'h20040000;
        // every mode pin combination at power-on
        for (i = 0; i < 8; i = i + 1) begin
            por(i[2:0]);
            rd(`SCC_ADDR, porExp(i[2:0]));
            check({31'h0, keyOpen}, 32'h1);
            check(oldCtl & 32'h00003F00, 32'h00000100);
        end
        // writes, sticky lock bits, key handling
        por(3'h3);
        wr(`SCC_ADDR, 32'hFFFFFFFF);
        check(systemClockControl, 32'hFFB7FF77);
        rd(`SCC_ADDR, 32'hFFB7FF77);
        wr(`SCC_ADDR, 32'h00000000);
        rd(`SCC_ADDR, 32'h0C000000);
        wr(`SCC_KEY_ADDR, 32'h12345678);
        check({31'h0, keyOpen}, 32'h0);
        wr(`SCC_ADDR, 32'hFFFFFFFF);
        rd(`SCC_ADDR, 32'h0C000000);
        wr(`SCC_KEY_ADDR, `SCC_KEY_OPEN);
        check({31'h0, keyOpen}, 32'h1);
        rd(`SCC_KEY_ADDR, 32'h0);
        check({31'h0, keyOpen}, 32'h0);
        wr(`SCC_KEY_ADDR, `SCC_KEY_OPEN);
        rd(32'h002FC284, 32'h0);
        // hard reset keeps unaffected fields, loads config fields
        backupClockActive <= 1'b1;
        wr(`SCC_ADDR, 32'hD3B9FF77);
        rd(`SCC_ADDR, 32'hDF39FF77);
        cfgWord <= 32'h00020000;
        hardResetPin <= 1'b1;
        repeat (6) @(posedge core_clk);
        wr(`SCC_ADDR, 32'h0);
        hardResetPin <= 1'b0;
        repeat (4) @(posedge core_clk);
        rd(`SCC_ADDR, (32'hDF39FF77 & ~`SCC_HARD_MASK) | `SCC_HARD_VALUE | 32'h20000);
        check({31'h0, keyOpen}, 32'h1);
        // switch-to-backup bit ignored while limp mode is off
        por(3'h0);
        wr(`SCC_ADDR, 32'h00800000);
        rd(`SCC_ADDR, 32'h00080000);
        complete_run;
    end
endmodule
